// *** core/ifd_pkg.sv ***
// Package of the instruction field decoder: field positions, encodings, states.
// Assumes a core that fetches one 14-bit word per instruction cycle.
package ifd_pkg;
  // ----------------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------------
  localparam int IW_W = 14;
  localparam int FADDR_LSB = 0;
  localparam int FADDR_W = 7;
  localparam int BITPOS_LSB = 7;
  localparam int BITPOS_W = 3;
  localparam int DEST_POS = 7;
  localparam int PTRSEL_SHORT_POS = 2;
  localparam int PTRSEL_LONG_POS = 6;
  localparam int STYLE_LSB = 0;
  localparam int OFS_W = 6;
  localparam int PTR_W = 16;
  localparam int DIR_LSB = 0;
  localparam int DIR_W = 3;
  // Oscillator periods per instruction cycle, minus one.
  localparam logic [1:0] OSC_PER_ICYC_M1 = 2'h3;
  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [13:0] ENC_PRESCALE = 14'h0062;
  localparam logic [13:0] ENC_STANDBY = 14'h0063;
  localparam logic [13:0] ENC_DIR_MASK = 14'h3FF8;
  localparam logic [13:0] ENC_DIR = 14'h0060;
  localparam logic [13:0] ENC_IND_MASK = 14'h3FF8;
  localparam logic [13:0] ENC_IND_LOAD = 14'h0010;
  localparam logic [13:0] ENC_IND_STORE = 14'h0018;
  localparam logic [13:0] ENC_PADD_MASK = 14'h3F80;
  localparam logic [13:0] ENC_PADD = 14'h3100;
  localparam logic [13:0] ENC_IDX_MASK = 14'h3F80;
  localparam logic [13:0] ENC_IDX_LOAD = 14'h3F00;
  localparam logic [13:0] ENC_IDX_STORE = 14'h3F80;
  localparam logic [13:0] ENC_FILE_MASK = 14'h3000;
  localparam logic [13:0] ENC_FILE = 14'h0000;
  localparam logic [13:0] ENC_BIT = 14'h1000;
  localparam logic [1:0] STYLE_PRE_INC = 2'h0;
  localparam logic [1:0] STYLE_PRE_DEC = 2'h1;
  localparam logic [1:0] STYLE_POST_INC = 2'h2;
  localparam logic [1:0] STYLE_POST_DEC = 2'h3;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [15:0] PTR_ONE = 16'h0001;
  // Operation codes presented to the datapath.
  typedef enum logic [3:0] {
    IFD_OP_OTHER = 4'h0, IFD_OP_PRESCALE = 4'h1, IFD_OP_STANDBY = 4'h2,
    IFD_OP_DIR = 4'h3, IFD_OP_PADD = 4'h4, IFD_OP_ILOAD = 4'h5,
    IFD_OP_ISTORE = 4'h6, IFD_OP_XLOAD = 4'h7, IFD_OP_XSTORE = 4'h8,
    IFD_OP_FILE = 4'h9, IFD_OP_BIT = 4'hA
  } ifd_op_t;
  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    IFD_ST_EXEC = 4'b0001, IFD_ST_FLUSH = 4'b0010, IFD_ST_EXTRA = 4'b0100,
    IFD_ST_IDLE = 4'b1000
  } ifd_state_t;
endpackage

// *** core/ifd_phase.sv ***
// Phase counter: divides the oscillator clock into instruction cycles.
// Assumes a synchronised reset and a clock enable from the decoder top.
`timescale 1ns/10ps
module ifd_phase (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  output logic icyc_end
);
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  // Count four oscillator periods per instruction cycle.
  always_comb begin
    ph_next = (ph_reg == ifd_pkg::OSC_PER_ICYC_M1) ? 2'h0 : ph_reg + 2'h1;
  end
  // Register the phase.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 2'h0;
    end else if (ce) begin
      ph_reg <= ph_next;
    end
  end
  assign icyc_end = (ph_reg == ifd_pkg::OSC_PER_ICYC_M1);
endmodule // ifd_phase

// *** core/ifd_top.sv ***
// Instruction field decoder of an 8-bit core: fields, pointers, cycle sequencing.
// Assumes words from program memory on the same clock and a datapath that
// performs the file access and flag updates that are asked for here.
`timescale 1ns/10ps
module ifd_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [13:0] instr_word,
  input wire logic instr_valid,
  input wire logic pc_change,
  input wire logic cond_true,
  output logic instr_take,
  output logic [3:0] op_code,
  output logic [6:0] file_addr,
  output logic [2:0] bit_pos,
  output logic dest_file,
  output logic file_read,
  output logic file_write,
  output logic ptr_sel,
  output logic [1:0] update_style,
  output logic [2:0] dir_sel,
  output logic [15:0] eff_addr,
  output logic [15:0] pointer_reg0,
  output logic [15:0] pointer_reg1,
  output logic acc_load,
  output logic mem_store,
  output logic zero_flag_upd,
  output logic expiry_flag_upd,
  output logic sleep_flag_upd,
  output logic nop_cycle,
  output logic extra_cycle
);
  // ----------------------------------------------------------------------
  // Reset synchroniser and instruction cycle timing
  // ----------------------------------------------------------------------
  logic rst_s1_reg;
  logic rst_n_reg;
  logic icyc_end;
  // Release reset through two flip-flops.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end
  ifd_phase u_phase (
    .mclk(mclk),
    .rst_n(rst_n_reg),
    .ce(ce),
    .icyc_end(icyc_end)
  );
  // ----------------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------------
  // Masked comparison so that don't-care positions never matter.
  function automatic logic enc_hit(input logic [13:0] w, input logic [13:0] m,
                                   input logic [13:0] v);
    enc_hit = ((w & m) == v);
  endfunction
  // Classify one instruction word into an operation code.
  function automatic ifd_pkg::ifd_op_t classify(input logic [13:0] w);
    if (w == ifd_pkg::ENC_PRESCALE) begin
      classify = ifd_pkg::IFD_OP_PRESCALE;
    end else if (w == ifd_pkg::ENC_STANDBY) begin
      classify = ifd_pkg::IFD_OP_STANDBY;
    end else if (enc_hit(w, ifd_pkg::ENC_DIR_MASK, ifd_pkg::ENC_DIR)) begin
      classify = ifd_pkg::IFD_OP_DIR;
    end else if (enc_hit(w, ifd_pkg::ENC_IND_MASK, ifd_pkg::ENC_IND_LOAD)) begin
      classify = ifd_pkg::IFD_OP_ILOAD;
    end else if (enc_hit(w, ifd_pkg::ENC_IND_MASK, ifd_pkg::ENC_IND_STORE)) begin
      classify = ifd_pkg::IFD_OP_ISTORE;
    end else if (enc_hit(w, ifd_pkg::ENC_PADD_MASK, ifd_pkg::ENC_PADD)) begin
      classify = ifd_pkg::IFD_OP_PADD;
    end else if (enc_hit(w, ifd_pkg::ENC_IDX_MASK, ifd_pkg::ENC_IDX_LOAD)) begin
      classify = ifd_pkg::IFD_OP_XLOAD;
    end else if (enc_hit(w, ifd_pkg::ENC_IDX_MASK, ifd_pkg::ENC_IDX_STORE)) begin
      classify = ifd_pkg::IFD_OP_XSTORE;
    end else if (enc_hit(w, ifd_pkg::ENC_FILE_MASK, ifd_pkg::ENC_FILE) &&
                 (w[13:8] != 6'h00)) begin
      classify = ifd_pkg::IFD_OP_FILE;
    end else if (enc_hit(w, ifd_pkg::ENC_FILE_MASK, ifd_pkg::ENC_BIT)) begin
      classify = ifd_pkg::IFD_OP_BIT;
    end else begin
      classify = ifd_pkg::IFD_OP_OTHER;
    end
  endfunction
  // Sign-extend a six-bit literal to pointer width.
  function automatic logic [15:0] sext6(input logic [5:0] k);
    sext6 = {{10{k[5]}}, k};
  endfunction
  // ----------------------------------------------------------------------
  // Pointer registers and decoded fields
  // ----------------------------------------------------------------------
  logic [15:0] ptr_reg [2];
  logic [15:0] ptr_next [2];
  ifd_pkg::ifd_op_t op_reg;
  ifd_pkg::ifd_op_t op_next;
  logic [6:0] fa_reg, fa_next;
  logic [2:0] bp_reg, bp_next;
  logic df_reg, df_next;
  logic fr_reg, fr_next;
  logic fw_reg, fw_next;
  logic ps_reg, ps_next;
  logic [1:0] us_reg, us_next;
  logic [2:0] ds_reg, ds_next;
  logic [15:0] ea_reg, ea_next;
  logic al_reg, al_next;
  logic ms_reg, ms_next;
  logic zf_reg, zf_next;
  logic sf_reg, sf_next;
  logic tk_reg, tk_next;
  logic np_reg, np_next;
  logic ex_reg, ex_next;
  ifd_pkg::ifd_state_t st_reg;
  ifd_pkg::ifd_state_t st_next;
  logic take;
  ifd_pkg::ifd_op_t cls;
  logic sel;
  logic [15:0] cur;
  logic [15:0] upd;
  logic [15:0] addr;
  // Compute the next decoded word, pointer values and sequencer state.
  always_comb begin
    cls = classify(instr_word);
    sel = (cls == ifd_pkg::IFD_OP_PADD || cls == ifd_pkg::IFD_OP_XLOAD ||
           cls == ifd_pkg::IFD_OP_XSTORE) ? instr_word[ifd_pkg::PTRSEL_LONG_POS]
                                          : instr_word[ifd_pkg::PTRSEL_SHORT_POS];
    cur = ptr_reg[sel];
    upd = cur;
    addr = cur;
    ptr_next[0] = ptr_reg[0];
    ptr_next[1] = ptr_reg[1];
    op_next = op_reg;
    fa_next = fa_reg;
    bp_next = bp_reg;
    df_next = df_reg;
    ps_next = ps_reg;
    us_next = us_reg;
    ds_next = ds_reg;
    ea_next = ea_reg;
    fr_next = icyc_end ? 1'b0 : fr_reg;
    fw_next = icyc_end ? 1'b0 : fw_reg;
    al_next = icyc_end ? 1'b0 : al_reg;
    ms_next = icyc_end ? 1'b0 : ms_reg;
    zf_next = icyc_end ? 1'b0 : zf_reg;
    sf_next = icyc_end ? 1'b0 : sf_reg;
    np_next = icyc_end ? 1'b0 : np_reg;
    ex_next = icyc_end ? 1'b0 : ex_reg;
    tk_next = icyc_end ? 1'b0 : tk_reg;
    st_next = st_reg;
    take = 1'b0;
    if (icyc_end) begin
      case (st_reg)
        ifd_pkg::IFD_ST_EXEC, ifd_pkg::IFD_ST_IDLE: begin
          take = instr_valid;
          st_next = instr_valid ? ifd_pkg::IFD_ST_EXEC : ifd_pkg::IFD_ST_IDLE;
        end
        ifd_pkg::IFD_ST_FLUSH: begin
          np_next = 1'b1;
          st_next = ifd_pkg::IFD_ST_IDLE;
        end
        ifd_pkg::IFD_ST_EXTRA: begin
          ex_next = 1'b1;
          st_next = ifd_pkg::IFD_ST_IDLE;
        end
        default: begin
          st_next = ifd_pkg::IFD_ST_IDLE;
        end
      endcase
    end
    if (take) begin
      tk_next = 1'b1;
      op_next = cls;
      fa_next = instr_word[ifd_pkg::FADDR_LSB +: ifd_pkg::FADDR_W];
      bp_next = instr_word[ifd_pkg::BITPOS_LSB +: ifd_pkg::BITPOS_W];
      df_next = instr_word[ifd_pkg::DEST_POS];
      ps_next = sel;
      us_next = instr_word[ifd_pkg::STYLE_LSB +: 2];
      ds_next = instr_word[ifd_pkg::DIR_LSB +: ifd_pkg::DIR_W];
      // File operands always read first, then store where the result goes.
      fr_next = (cls == ifd_pkg::IFD_OP_FILE || cls == ifd_pkg::IFD_OP_BIT);
      fw_next = (cls == ifd_pkg::IFD_OP_BIT) ||
                (cls == ifd_pkg::IFD_OP_FILE && instr_word[ifd_pkg::DEST_POS]);
      sf_next = (cls == ifd_pkg::IFD_OP_STANDBY);
      case (cls)
        ifd_pkg::IFD_OP_PADD: begin
          upd = cur + sext6(instr_word[ifd_pkg::OFS_W-1:0]);
          ptr_next[sel] = upd;
        end
        ifd_pkg::IFD_OP_ILOAD, ifd_pkg::IFD_OP_ISTORE: begin
          // Pre styles move before the access, post styles after it.
          case (instr_word[1:0])
            ifd_pkg::STYLE_PRE_INC: begin
              upd = cur + ifd_pkg::PTR_ONE;
              addr = upd;
            end
            ifd_pkg::STYLE_PRE_DEC: begin
              upd = cur - ifd_pkg::PTR_ONE;
              addr = upd;
            end
            ifd_pkg::STYLE_POST_INC: begin
              upd = cur + ifd_pkg::PTR_ONE;
            end
            default: begin
              upd = cur - ifd_pkg::PTR_ONE;
            end
          endcase
          ptr_next[sel] = upd;
          al_next = (cls == ifd_pkg::IFD_OP_ILOAD);
          ms_next = (cls == ifd_pkg::IFD_OP_ISTORE);
          zf_next = (cls == ifd_pkg::IFD_OP_ILOAD);
          ea_next = addr;
          if (addr[ifd_pkg::PTR_W-1]) begin
            st_next = ifd_pkg::IFD_ST_EXTRA;
          end
        end
        ifd_pkg::IFD_OP_XLOAD, ifd_pkg::IFD_OP_XSTORE: begin
          addr = cur + sext6(instr_word[ifd_pkg::OFS_W-1:0]);
          ea_next = addr;
          al_next = (cls == ifd_pkg::IFD_OP_XLOAD);
          ms_next = (cls == ifd_pkg::IFD_OP_XSTORE);
          zf_next = (cls == ifd_pkg::IFD_OP_XLOAD);
          if (addr[ifd_pkg::PTR_W-1]) begin
            st_next = ifd_pkg::IFD_ST_EXTRA;
          end
        end
        default: begin
          ea_next = ea_reg;
        end
      endcase
      if (pc_change || cond_true) begin
        st_next = ifd_pkg::IFD_ST_FLUSH;
      end
    end
  end
  // Register decoded fields, pointers and state.
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ptr_reg[0] <= ifd_pkg::PTR_RST;
      ptr_reg[1] <= ifd_pkg::PTR_RST;
      op_reg <= ifd_pkg::IFD_OP_OTHER;
      fa_reg <= 7'h00;
      bp_reg <= 3'h0;
      df_reg <= 1'b0;
      fr_reg <= 1'b0;
      fw_reg <= 1'b0;
      ps_reg <= 1'b0;
      us_reg <= 2'h0;
      ds_reg <= 3'h0;
      ea_reg <= 16'h0000;
      al_reg <= 1'b0;
      ms_reg <= 1'b0;
      zf_reg <= 1'b0;
      sf_reg <= 1'b0;
      tk_reg <= 1'b0;
      np_reg <= 1'b0;
      ex_reg <= 1'b0;
      st_reg <= ifd_pkg::IFD_ST_IDLE;
    end else if (ce) begin
      ptr_reg[0] <= ptr_next[0];
      ptr_reg[1] <= ptr_next[1];
      op_reg <= op_next;
      fa_reg <= fa_next;
      bp_reg <= bp_next;
      df_reg <= df_next;
      fr_reg <= fr_next;
      fw_reg <= fw_next;
      ps_reg <= ps_next;
      us_reg <= us_next;
      ds_reg <= ds_next;
      ea_reg <= ea_next;
      al_reg <= al_next;
      ms_reg <= ms_next;
      zf_reg <= zf_next;
      sf_reg <= sf_next;
      tk_reg <= tk_next;
      np_reg <= np_next;
      ex_reg <= ex_next;
      st_reg <= st_next;
    end
  end
  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Every output comes from a register above.
  assign instr_take = tk_reg;
  assign op_code = op_reg;
  assign file_addr = fa_reg;
  assign bit_pos = bp_reg;
  assign dest_file = df_reg;
  assign file_read = fr_reg;
  assign file_write = fw_reg;
  assign ptr_sel = ps_reg;
  assign update_style = us_reg;
  assign dir_sel = ds_reg;
  assign eff_addr = ea_reg;
  assign pointer_reg0 = ptr_reg[0];
  assign pointer_reg1 = ptr_reg[1];
  assign acc_load = al_reg;
  assign mem_store = ms_reg;
  assign zero_flag_upd = zf_reg;
  assign expiry_flag_upd = sf_reg;
  assign sleep_flag_upd = sf_reg;
  assign nop_cycle = np_reg;
  assign extra_cycle = ex_reg;
endmodule // ifd_top

// *** sim/ifd_chk.sv ***
// Assertion checker for the instruction field decoder top.
// Assumes a bind to ifd_top with ce held high.
`timescale 1ns/10ps
module ifd_chk (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [13:0] instr_word,
  input wire logic pc_change,
  input wire logic cond_true,
  input wire logic instr_take,
  input wire logic [3:0] op_code,
  input wire logic [6:0] file_addr,
  input wire logic [2:0] bit_pos,
  input wire logic dest_file,
  input wire logic file_read,
  input wire logic file_write,
  input wire logic ptr_sel,
  input wire logic [1:0] update_style,
  input wire logic [15:0] eff_addr,
  input wire logic [15:0] pointer_reg0,
  input wire logic acc_load,
  input wire logic mem_store,
  input wire logic zero_flag_upd,
  input wire logic expiry_flag_upd,
  input wire logic sleep_flag_upd,
  input wire logic nop_cycle,
  input wire logic extra_cycle
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // ----------
  // Properties
  // ----------
  // A take stands one whole instruction cycle of four clocks.
  AST_TAKE_LEN: assert property ($rose(instr_take) |-> instr_take [*4])
    else $error("take pulse shorter than four clocks");
  // Fields come from the word held at the taking edge.
  AST_FIELDS: assert property ($rose(instr_take) |->
    file_addr == $past(instr_word[6:0]) && bit_pos == $past(instr_word[9:7])
    && dest_file == $past(instr_word[7]))
    else $error("operand fields differ from taken word");
  // File and bit operands are always read; file operands are written back only when d is one.
  AST_FILE_RMW: assert property (instr_take && op_code == 4'h9 |->
    file_read && file_write == dest_file)
    else $error("file operand access wrong");
  AST_BIT_READ: assert property (instr_take && op_code == 4'hA |-> file_read)
    else $error("bit operand not read");
  // Standby pulses both flag updates together, and only standby does.
  AST_STANDBY: assert property (sleep_flag_upd |-> instr_take && expiry_flag_upd
    && op_code == 4'h2)
    else $error("standby flag update wrong");
  AST_PRESCALE: assert property (instr_take && op_code == 4'h1 |->
    !zero_flag_upd && !expiry_flag_upd && !sleep_flag_upd)
    else $error("prescaler load touched flags");
  // Loads update the zero flag; stores and pointer adds leave it alone.
  AST_LOAD_ZERO: assert property (instr_take && op_code inside {4'h5, 4'h7} |->
    zero_flag_upd && acc_load)
    else $error("indirect load without zero update");
  AST_STORE_FLAG: assert property (instr_take && op_code inside {4'h4, 4'h6, 4'h8} |->
    !zero_flag_upd && mem_store == (op_code != 4'h4))
    else $error("store or pointer add wrong");
  // Pointer update, style field and access address follow the taken word.
  AST_PTR_STYLE: assert property ($rose(instr_take) && !ptr_sel
    && op_code inside {4'h5, 4'h6} |-> update_style == $past(instr_word[1:0])
    && pointer_reg0 == $past(pointer_reg0) + ($past(instr_word[0]) ? 16'hFFFF : 16'h0001)
    && eff_addr == ($past(instr_word[1]) ? $past(pointer_reg0) : pointer_reg0))
    else $error("pointer update style wrong");
  // A flushing word is followed by one full no-op cycle.
  AST_NOP: assert property ($rose(instr_take) && $past(pc_change || cond_true) |->
    ##4 nop_cycle [*4])
    else $error("no-op cycle missing");
  AST_EXTRA: assert property ($rose(instr_take) && op_code inside {4'h5, 4'h6, 4'h7, 4'h8}
    && eff_addr[15] && !$past(pc_change || cond_true) |-> ##4 extra_cycle)
    else $error("extra cycle missing");
endmodule // ifd_chk

// *** sim/ifd_fetch.sv ***
// Program memory fetch model: queues words and holds each until it is taken.
// Assumes the take output stands four clocks for every taken word.
`timescale 1ns/10ps
module ifd_fetch (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic instr_take,
  output logic [13:0] instr_word,
  output logic instr_valid,
  output logic pc_change,
  output logic cond_true,
  output logic took
);
  logic [15:0] q[$];
  logic [1:0] hold_reg;
  // Queues one word with its branch flags.
  task automatic push(input logic [13:0] w, input logic pc, input logic ct);
    q.push_back({pc, ct, w});
  endtask
  // Holds a word until taken, then shows its inverse while nothing is offered.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {pc_change, cond_true, instr_word} <= 16'h0000;
      instr_valid <= 1'b0;
      hold_reg <= 2'h0;
      took <= 1'b0;
    end else begin
      took <= 1'b0;
      if (hold_reg != 2'h0) hold_reg <= hold_reg - 2'h1;
      if (instr_valid && instr_take && hold_reg == 2'h0) begin
        instr_valid <= 1'b0;
        instr_word <= ~instr_word;
        hold_reg <= 2'h3;
        took <= 1'b1;
      end else if (!instr_valid && q.size() != 0) begin
        {pc_change, cond_true, instr_word} <= q.pop_front();
        instr_valid <= 1'b1;
      end
    end
  end
endmodule // ifd_fetch

// *** sim/testbench.sv ***
// Self-checking bench of the decoder: words are fed through the fetch model.
// Holds ce high except for one eight-clock freeze check; ops: 1 prescale .. 8 idx store, 9 file, A bit.
`timescale 1ns/10ps
module testbench;
  logic mclk, arst_n, ce, instr_valid, pc_change, cond_true, took;
  logic [13:0] instr_word;
  logic instr_take, dest_file, file_read, file_write, ptr_sel, acc_load, mem_store;
  logic zero_flag_upd, expiry_flag_upd, sleep_flag_upd, nop_cycle, extra_cycle;
  logic [3:0] op_code;
  logic [6:0] file_addr;
  logic [2:0] bit_pos, dir_sel;
  logic [1:0] update_style;
  logic [15:0] eff_addr, pointer_reg0, pointer_reg1;
  logic [15:0] p_reg [2];
  int n_fail, num_checks;
  ifd_top dut (.mclk, .arst_n, .ce, .instr_word, .instr_valid, .pc_change, .cond_true,
    .instr_take, .op_code, .file_addr, .bit_pos, .dest_file, .file_read, .file_write,
    .ptr_sel, .update_style, .dir_sel, .eff_addr, .pointer_reg0, .pointer_reg1, .acc_load,
    .mem_store, .zero_flag_upd, .expiry_flag_upd, .sleep_flag_upd, .nop_cycle, .extra_cycle);
  ifd_fetch fetch (.mclk, .rst_n(arst_n), .instr_take, .instr_word, .instr_valid,
    .pc_change, .cond_true, .took);
  // -----
  // Tasks
  // -----
  // Counts one comparison and reports it when it fails.
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask
  // Feeds one word, checks the decoded outputs, then optionally the next cycle.
  task automatic exec(input logic [13:0] w, input logic pc, input logic ct,
                      input logic [3:0] op, input logic gap);
    logic n, ind;
    logic [15:0] p, e;
    int t;
    fetch.push(w, pc, ct);
    t = 0;
    do begin
      @(posedge mclk);
      #1;
      t++;
    end while (took !== 1'b1 && t < 60);
    n = (op == 4'h4 || op == 4'h7 || op == 4'h8) ? w[6] : w[2];
    ind = op inside {4'h5, 4'h6, 4'h7, 4'h8};
    p = p_reg[n];
    e = p + {{10{w[5]}}, w[5:0]};
    if (op == 4'h4) p_reg[n] = e;
    if (op == 4'h5 || op == 4'h6) begin
      p_reg[n] = w[0] ? p - 16'h0001 : p + 16'h0001;
      e = w[1] ? p : p_reg[n];
    end
    chk(took === 1'b1 && op_code === op, "word not taken or wrong op");
    chk(pointer_reg0 === p_reg[0] && pointer_reg1 === p_reg[1], "pointer value");
    if (ind || op == 4'h4) chk(ptr_sel === n, "pointer select");
    if (ind) chk(eff_addr === e, "effective address");
    if (op == 4'h5 || op == 4'h6) chk(update_style === w[1:0], "update style");
    if (op == 4'h9) chk(file_write === w[7] && dest_file === w[7], "destination");
    if (op > 4'h8) chk(file_addr === w[6:0] && file_read === 1'b1, "file address");
    if (op == 4'hA) chk(bit_pos === w[9:7], "bit position");
    if (op == 4'h3) chk(dir_sel === w[2:0], "direction select");
    chk(zero_flag_upd === (op == 4'h5 || op == 4'h7), "zero flag update");
    chk(acc_load === (op == 4'h5 || op == 4'h7), "accumulator load");
    chk(mem_store === (op == 4'h6 || op == 4'h8), "memory store");
    chk(sleep_flag_upd === (op == 4'h2) && expiry_flag_upd === (op == 4'h2), "standby");
    if (gap) begin
      repeat (3) @(posedge mclk);
      #1;
      chk(nop_cycle === (pc | ct) && instr_take === 1'b0, "no-op cycle");
      chk(extra_cycle === (!(pc | ct) && ind && e[15]), "extra cycle");
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Clock of 10 ns.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Cuts a hang short.
  initial begin
    #20000;
    n_fail++;
    $display("ERROR at %0t: timeout", $time);
    end_sim();
  end
  // Main sequence of words.
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    n_fail = 0;
    num_checks = 0;
    p_reg[0] = 16'h0000;
    p_reg[1] = 16'h0000;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    exec(14'h07A5, 1'b0, 1'b0, 4'h9, 1'b1);
    exec(14'h0A7F, 1'b0, 1'b0, 4'h9, 1'b1);
    exec(14'h1380, 1'b0, 1'b0, 4'hA, 1'b1);
    exec(14'h0062, 1'b0, 1'b0, 4'h1, 1'b1);
    exec(14'h0063, 1'b0, 1'b0, 4'h2, 1'b1);
    for (int i = 5; i < 8; i++) exec(14'h0060 + 14'(i), 1'b0, 1'b0, 4'h3, 1'b1);
    exec(14'h3160, 1'b0, 1'b0, 4'h4, 1'b1);
    exec(14'h0014, 1'b0, 1'b0, 4'h5, 1'b1);
    for (int s = 0; s < 4; s++) exec(14'h0010 + 14'(s ^ 1), 1'b0, 1'b0, 4'h5, 1'b1);
    for (int s = 0; s < 4; s++) exec(14'h001C + 14'(s), 1'b0, 1'b0, 4'h6, 1'b1);
    exec(14'h3F3F, 1'b0, 1'b0, 4'h7, 1'b1);
    exec(14'h3FC1, 1'b0, 1'b0, 4'h8, 1'b1);
    // Holding the clock enable low must freeze the standing extra cycle.
    @(posedge mclk);
    ce <= 1'b0;
    repeat (8) @(posedge mclk);
    ce <= 1'b1;
    #1;
    chk(extra_cycle === 1'b1 && pointer_reg1 === p_reg[1], "clock enable freeze");
    exec(14'h07A5, 1'b1, 1'b0, 4'h9, 1'b1);
    exec(14'h0011, 1'b0, 1'b1, 4'h5, 1'b1);
    exec(14'h0062, 1'b0, 1'b0, 4'h1, 1'b0);
    exec(14'h1380, 1'b0, 1'b0, 4'hA, 1'b0);
    exec(14'h0063, 1'b0, 1'b0, 4'h2, 1'b1);
    end_sim();
  end
endmodule // testbench
bind ifd_top ifd_chk chk (.mclk, .arst_n, .instr_word, .pc_change, .cond_true, .instr_take,
  .op_code, .file_addr, .bit_pos, .dest_file, .file_read, .file_write, .ptr_sel,
  .update_style, .eff_addr, .pointer_reg0, .acc_load, .mem_store, .zero_flag_upd,
  .expiry_flag_upd, .sleep_flag_upd, .nop_cycle, .extra_cycle);
